// ---- hiet_hart_model.sv ----
// behavioural pipeline of the hart that consumes traps and requests returns
`timescale 1ns/1ps
module hiet_hart_model
#(
  parameter logic [31:0] HOME_PC = 32'h0000_4000
)(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic        machine_trap_return_req_in,
  input  wire logic        redirect_in,
  input  wire logic [31:0] new_pc_in,
  output logic             boundary_out,
  output logic             machine_trap_return_out,
  output logic      [31:0] pc_out
);
  // ------------------------------------------
  // pipeline behaviour
  // ------------------------------------------
  logic [31:0] targets [$];
  logic        beat;
  // return request stays up until the redirect is seen, then drops
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      beat     <= 1'b0;
      machine_trap_return_out <= 1'b0;
    end
    else
    begin
      beat <= ~beat;
      if (redirect_in)
      begin
        targets.push_back(new_pc_in);
        machine_trap_return_out <= 1'b0;
      end
      else if (machine_trap_return_req_in)
        machine_trap_return_out <= 1'b1;
    end
  end
  // slow mode offers a boundary only every other cycle
  assign boundary_out = ~rst_in & (~slow_in | beat);
  assign pc_out       = HOME_PC;
endmodule : hiet_hart_model

// ---- hiet_pick.sv ----
// selects the interrupt to take: highest enabled pending number wins
`timescale 1ns/1ps
module hiet_pick
  import hiet_pkg::*;
(
  hiet_trap_if.sel t
);
  wire [63:0] live = t.pending & t.enable;

  // priority encoder, higher numbers first
  function automatic logic [CODE_W-1:0] top_bit(input logic [63:0] v);
    logic [CODE_W-1:0] r;
    r = '0;
    for (int i = 0; i < 64; i++)
    begin
      if (v[i])
      begin
        r = CODE_W'(i);
      end
    end
    return r;
  endfunction : top_bit

  assign t.take = t.global_en & (|live);
  assign t.code = top_bit(live);
endmodule : hiet_pick

// ---- hiet_pkg.sv ----
// shared constants, register map and helpers for the hart interrupt entry/exit block
package hiet_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  A_STATUS  = 8'h00;
  localparam logic [7:0]  A_IE_LO   = 8'h04;
  localparam logic [7:0]  A_IE_HI   = 8'h08;
  localparam logic [7:0]  A_IP_LO   = 8'h0C;
  localparam logic [7:0]  A_IP_HI   = 8'h10;
  localparam logic [7:0]  A_TVEC    = 8'h14;
  localparam logic [7:0]  A_EPC     = 8'h18;
  localparam logic [7:0]  A_CAU_LO  = 8'h1C;
  localparam logic [7:0]  A_CAU_HI  = 8'h20;
  localparam logic [7:0]  A_FAB_EN  = 8'h24;
  localparam logic [7:0]  A_ECC_ST  = 8'h28;
  localparam logic [7:0]  A_ECC_IE  = 8'h2C;
  localparam logic [7:0]  A_ECC_CNT = 8'h30;
  localparam logic [7:0]  A_EV_ST   = 8'h34;
  localparam logic [7:0]  A_EV_MSK  = 8'h38;
  localparam logic [7:0]  A_PRIV    = 8'h3C;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int ST_W    = 13;
  localparam int ST_SIE  = 1;
  localparam int ST_MIE  = 3;
  localparam int ST_SUPERVISOR_PREV_INT_ENABLE = 5;
  localparam int ST_MACHINE_PREV_INT_ENABLE = 7;
  localparam int ST_SPP  = 8;
  localparam int ST_MPPL = 11;
  localparam int ST_MPPH = 12;
  localparam logic [ST_W-1:0] ST_RST = 13'h0000;

  // ----------------------------------------------------------------
  // enable / pending layout
  // ----------------------------------------------------------------
  localparam int          N_LOCAL  = 48;
  localparam int          N_STD    = 6;
  localparam int          N_PLAIN  = 16;
  localparam int          N_FAB    = 32;
  localparam int          CODE_W   = 6;
  localparam logic [63:0] IE_WMASK = 64'hFFFF_FFFF_FFFF_0AAA;
  localparam int          ECC_COR_LINE = 13;
  localparam int          ECC_ERR_LINE = 14;

  // trap vector and privilege
  localparam logic [1:0]  VEC_DIRECT   = 2'h0;
  localparam logic [1:0]  VEC_VECTORED = 2'h1;
  localparam int          VEC_SHIFT    = 2;
  localparam logic [1:0]  PRIV_M       = 2'h3;
  localparam int          CAUSE_INT    = 31;

  // ecc status bits, sticky events
  localparam int ECC_COR = 0;
  localparam int ECC_ERR = 1;
  localparam int CNT_W   = 16;
  localparam int EV_ENTRY = 0;
  localparam int EV_RET   = 1;
  localparam int EV_ECC   = 2;
  localparam int EV_W     = 3;

  typedef enum logic [1:0] {
    HIET_IDLE  = 2'b00,
    HIET_ENTER = 2'b01,
    HIET_LEAVE = 2'b10
  } hiet_state_t;

  // place the six standard pending/enable lines at bits 1,3,...,11
  function automatic logic [N_PLAIN-1:0] hiet_spread(input logic [N_STD-1:0] s);
    logic [N_PLAIN-1:0] r;
    r = '0;
    for (int i = 0; i < N_STD; i++)
    begin
      r[2*i+1] = s[i];
    end
    return r;
  endfunction : hiet_spread

  // handler address: base, or base plus four times the cause when vectored
  function automatic logic [31:0] hiet_target(input logic [31:0] base, input logic [1:0] mode,
                                              input logic [CODE_W-1:0] code);
    logic [31:0] off;
    off = 32'({code, 2'b00});
    return (mode == VEC_VECTORED) ? (base + off) : base;
  endfunction : hiet_target

endpackage : hiet_pkg

// ---- hiet_sync.sv ----
// two-flop synchroniser for interrupt lines
`timescale 1ns/1ps
module hiet_sync
  import hiet_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : hiet_sync

// ---- hiet_top.sv ----
// hart interrupt entry/exit controller with apb register access
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module hiet_top
  import hiet_pkg::*;
#(
  parameter bit MONITOR_CORE = 1'b1
)(
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic [ADDR_W-1:0] PADDR_IN,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  input  wire logic [N_STD-1:0]  STD_IRQ_IN,
  input  wire logic [N_PLAIN-1:0] LOCAL_IRQ_IN,
  input  wire logic [N_FAB-1:0]  FABRIC_IRQ_IN,
  input  wire logic              ECC_COR_IN,
  input  wire logic              ECC_ERR_IN,
  input  wire logic              BOUNDARY_IN,
  input  wire logic              MACHINE_TRAP_RETURN_IN,
  input  wire logic [31:0]       PC_IN,
  output logic                   REDIRECT_OUT,
  output logic      [31:0]       NEW_PC_OUT,
  output logic      [1:0]        PRIV_OUT,
  output logic                   IRQ_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hiet_state_t        state;
  hiet_state_t        next_state;
  logic [ST_W-1:0]    status;
  logic [ST_W-1:0]    next_status;
  logic [63:0]        ie;
  logic [31:0]        tvec_base;
  logic [1:0]         tvec_mode;
  logic [31:0]        epc;
  logic [CODE_W-1:0]  cause_code;
  logic               cause_int;
  logic [N_FAB-1:0]   fab_en;
  logic [1:0]         ecc_st;
  logic [1:0]         ecc_ie;
  logic [CNT_W-1:0]   ecc_cnt;
  logic [EV_W-1:0]    ev_st;
  logic [EV_W-1:0]    ev_msk;

  localparam logic [N_FAB-1:0] FAB_RST = MONITOR_CORE ? '1 : '0;

  // ----------------------------------------------------------------
  // synchronised interrupt lines
  // ----------------------------------------------------------------
  logic [N_STD-1:0]   std_s;
  logic [N_PLAIN-1:0] loc_s;
  logic [N_FAB-1:0]   fab_s;

  // lines are resampled before any decision so entry sees stable levels
  hiet_sync #(.W(N_STD+N_PLAIN+N_FAB)) u_sync (
    .clk (CLK_IN),
    .rst (RST_IN),
    .d   ({STD_IRQ_IN, LOCAL_IRQ_IN, FABRIC_IRQ_IN}),
    .q   ({std_s, loc_s, fab_s})
  );

  // ----------------------------------------------------------------
  // local interrupt assembly and selection
  // ----------------------------------------------------------------
  logic [N_LOCAL-1:0] local_lines;
  wire  [1:0]         ecc_line = ecc_st & ecc_ie;

  // fabric lines sit above the plain peripheral lines; ecc lines replace two of them
  always_comb
  begin
    local_lines               = {fab_s & fab_en, loc_s};
    local_lines[ECC_COR_LINE] = ecc_line[ECC_COR];
    local_lines[ECC_ERR_LINE] = ecc_line[ECC_ERR];
  end

  wire [63:0] pending = {local_lines, hiet_spread(std_s)};

  hiet_trap_if tif ();
  assign tif.pending   = pending;
  assign tif.enable    = ie;
  assign tif.global_en = status[ST_MIE];

  hiet_pick u_pick (
    .t (tif.sel)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       acc    = PSEL_IN & PENABLE_IN;
  wire       wr_go  = acc & PWRITE_IN & PREADY_OUT;
  wire       next_pready = acc & ~PREADY_OUT;
  wire       hit_st  = PADDR_IN == A_STATUS;
  wire       hit_ilo = PADDR_IN == A_IE_LO;
  wire       hit_ihi = PADDR_IN == A_IE_HI;
  wire       hit_tv  = PADDR_IN == A_TVEC;
  wire       hit_epc = PADDR_IN == A_EPC;
  wire       hit_fab = PADDR_IN == A_FAB_EN;
  wire       hit_ecs = PADDR_IN == A_ECC_ST;
  wire       hit_eci = PADDR_IN == A_ECC_IE;
  wire       hit_evs = PADDR_IN == A_EV_ST;
  wire       hit_evm = PADDR_IN == A_EV_MSK;
  wire       mapped  = hit_st | hit_ilo | hit_ihi | hit_tv | hit_epc | hit_fab | hit_ecs
                     | hit_eci | hit_evs | hit_evm | (PADDR_IN == A_IP_LO)
                     | (PADDR_IN == A_IP_HI) | (PADDR_IN == A_CAU_LO)
                     | (PADDR_IN == A_CAU_HI) | (PADDR_IN == A_ECC_CNT)
                     | (PADDR_IN == A_PRIV);

  // read multiplexer; unmapped words read zero with an error
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (PADDR_IN)
      A_STATUS:  rd_mux = 32'(status);
      A_IE_LO:   rd_mux = ie[31:0];
      A_IE_HI:   rd_mux = ie[63:32];
      A_IP_LO:   rd_mux = pending[31:0];
      A_IP_HI:   rd_mux = pending[63:32];
      A_TVEC:    rd_mux = {tvec_base[31:2], tvec_mode};
      A_EPC:     rd_mux = epc;
      A_CAU_LO:  rd_mux = 32'(cause_code);
      A_CAU_HI:  rd_mux = {cause_int, 31'h0000_0000};
      A_FAB_EN:  rd_mux = fab_en;
      A_ECC_ST:  rd_mux = 32'(ecc_st);
      A_ECC_IE:  rd_mux = 32'(ecc_ie);
      A_ECC_CNT: rd_mux = 32'(ecc_cnt);
      A_EV_ST:   rd_mux = 32'(ev_st);
      A_EV_MSK:  rd_mux = 32'(ev_msk);
      A_PRIV:    rd_mux = 32'(PRIV_OUT);
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // trap entry / return decisions
  // ----------------------------------------------------------------
  // a committing software write holds off hardware updates for one cycle,
  // so neither side loses its update; pipeline keeps its request up meanwhile
  wire idle     = state == HIET_IDLE;
  wire machine_trap_return_go  = idle & MACHINE_TRAP_RETURN_IN & ~wr_go;
  wire trap_go  = idle & BOUNDARY_IN & tif.take & ~MACHINE_TRAP_RETURN_IN & ~wr_go;
  wire [31:0] vec_pc = hiet_target(tvec_base, tvec_mode, tif.code);

  always_comb
  begin
    next_state = state;
    unique case (state)
      HIET_IDLE:
      begin
        if (machine_trap_return_go)
        begin
          next_state = HIET_LEAVE;
        end
        else if (trap_go)
        begin
          next_state = HIET_ENTER;
        end
      end
      HIET_ENTER: next_state = HIET_IDLE;
      HIET_LEAVE: next_state = HIET_IDLE;
      default:    next_state = HIET_IDLE;
    endcase
  end

  // status word: hardware sequence, else software write
  always_comb
  begin
    next_status = status;
    if (trap_go)
    begin
      next_status[ST_MACHINE_PREV_INT_ENABLE]         = status[ST_MIE];
      next_status[ST_MIE]          = 1'b0;
      next_status[ST_MPPH:ST_MPPL] = PRIV_OUT;
    end
    else if (machine_trap_return_go)
    begin
      next_status[ST_MIE] = status[ST_MACHINE_PREV_INT_ENABLE];
    end
    else if (wr_go & hit_st)
    begin
      next_status = PWDATA_IN[ST_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // sequencer and architectural registers
  // ----------------------------------------------------------------
  // every entry update commits on the same edge
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      state        <= HIET_IDLE;
      status       <= ST_RST;
      PRIV_OUT     <= PRIV_M;
      epc          <= 32'h0000_0000;
      cause_code   <= '0;
      cause_int    <= 1'b0;
      REDIRECT_OUT <= 1'b0;
      NEW_PC_OUT   <= 32'h0000_0000;
    end
    else
    begin
      state        <= next_state;
      status       <= next_status;
      REDIRECT_OUT <= trap_go | machine_trap_return_go;
      if (trap_go)
      begin
        epc        <= PC_IN;
        cause_int  <= 1'b1;
        cause_code <= tif.code;
        PRIV_OUT   <= PRIV_M;
        NEW_PC_OUT <= vec_pc;
      end
      else if (machine_trap_return_go)
      begin
        PRIV_OUT   <= status[ST_MPPH:ST_MPPL];
        NEW_PC_OUT <= epc;
      end
      else if (wr_go & hit_epc)
      begin
        epc <= {PWDATA_IN[31:2], 2'b00};
      end
    end
  end

  // enables and vector base; reserved modes keep the previous mode
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      ie        <= 64'h0000_0000_0000_0000;
      tvec_base <= 32'h0000_0000;
      tvec_mode <= VEC_DIRECT;
      fab_en    <= FAB_RST;
    end
    else if (wr_go)
    begin
      if (hit_ilo)
        ie[31:0]  <= PWDATA_IN & IE_WMASK[31:0];
      if (hit_ihi)
        ie[63:32] <= PWDATA_IN & IE_WMASK[63:32];
      if (hit_tv)
      begin
        tvec_base <= {PWDATA_IN[31:2], 2'b00};
        if (PWDATA_IN[1:0] <= VEC_VECTORED)
          tvec_mode <= PWDATA_IN[1:0];
      end
      if (hit_fab)
        fab_en <= PWDATA_IN;
    end
  end

  // ----------------------------------------------------------------
  // ecc status, enable and counter
  // ----------------------------------------------------------------
  wire [1:0]  ecc_set  = {ECC_ERR_IN, ECC_COR_IN};
  wire [1:0]  ecc_clr  = (wr_go & hit_ecs) ? PWDATA_IN[1:0] : 2'b00;
  wire        cnt_full = &ecc_cnt;

  // new error wins over a clear in the same cycle; counter saturates
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      ecc_st  <= 2'b00;
      ecc_ie  <= 2'b00;
      ecc_cnt <= '0;
    end
    else
    begin
      ecc_st <= (ecc_st & ~ecc_clr) | ecc_set;
      if (wr_go & hit_eci)
        ecc_ie <= PWDATA_IN[1:0];
      if ((|ecc_set) & ~cnt_full)
        ecc_cnt <= ecc_cnt + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // event interrupt and apb answer
  // ----------------------------------------------------------------
  wire [EV_W-1:0] ev_set = {|ecc_set, machine_trap_return_go, trap_go};
  wire [EV_W-1:0] ev_clr = (wr_go & hit_evs) ? PWDATA_IN[EV_W-1:0] : '0;
  wire [EV_W-1:0] next_ev = (ev_st & ~ev_clr) | ev_set;

  // irq is registered from next values so it tracks status without lag
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      ev_st       <= '0;
      ev_msk      <= '0;
      IRQ_OUT     <= 1'b0;
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end
    else
    begin
      ev_st      <= next_ev;
      if (wr_go & hit_evm)
        ev_msk <= PWDATA_IN[EV_W-1:0];
      IRQ_OUT     <= |(next_ev & ((wr_go & hit_evm) ? PWDATA_IN[EV_W-1:0] : ev_msk));
      PREADY_OUT  <= next_pready;
      PRDATA_OUT  <= (next_pready & ~PWRITE_IN) ? rd_mux : 32'h0000_0000;
      PSLVERR_OUT <= next_pready & ~mapped;
    end
  end

endmodule : hiet_top

// ---- hiet_top_assertions.sv ----
// port-level assertions for the hart interrupt entry/exit block
`timescale 1ns/1ps
module hiet_top_checker
  import hiet_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        BOUNDARY_IN,
  input wire logic        MACHINE_TRAP_RETURN_IN,
  input wire logic        REDIRECT_OUT,
  input wire logic [31:0] NEW_PC_OUT,
  input wire logic [1:0]  PRIV_OUT,
  input wire logic        IRQ_OUT
);
  // ------------------------------------------
  // helpers and checks
  // ------------------------------------------
  logic wr_commit;
  // a write lands only at the edge where the slave answers
  assign wr_commit = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  ready_one_wait_a: assert property ((PSEL_IN && !PENABLE_IN) ##1 (PSEL_IN && PENABLE_IN)
    |-> !PREADY_OUT ##1 PREADY_OUT) else $error("bus answer not in second access cycle");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held too long");
  slverr_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
  rdata_idle_a: assert property (!PREADY_OUT || PWRITE_IN |-> PRDATA_OUT == 32'h0000_0000)
    else $error("read data outside a read answer");
  redirect_pulse_a: assert property (REDIRECT_OUT |=> !REDIRECT_OUT) else $error("redirects too close");
  redirect_cause_a: assert property (REDIRECT_OUT |-> $past(BOUNDARY_IN || MACHINE_TRAP_RETURN_IN))
    else $error("redirect off an instruction boundary");
  entry_priv_a: assert property (REDIRECT_OUT && !$past(MACHINE_TRAP_RETURN_IN) |-> PRIV_OUT == PRIV_M)
    else $error("handler not in machine mode");
  priv_change_a: assert property ($changed(PRIV_OUT) |-> REDIRECT_OUT)
    else $error("privilege moved without redirect");
  newpc_hold_a: assert property ($changed(NEW_PC_OUT) |-> REDIRECT_OUT)
    else $error("target moved without redirect");
  irq_clear_a: assert property ($fell(IRQ_OUT) |-> $past(wr_commit) || $past(wr_commit, 2) || $past(wr_commit, 3))
    else $error("interrupt dropped without a write");

  // main scenarios reached
  trap_c: cover property (REDIRECT_OUT);
  unmapped_c: cover property (PSLVERR_OUT);
  irq_c: cover property ($rose(IRQ_OUT));
endmodule : hiet_top_checker

bind hiet_top hiet_top_checker i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .BOUNDARY_IN(BOUNDARY_IN), .MACHINE_TRAP_RETURN_IN(MACHINE_TRAP_RETURN_IN), .REDIRECT_OUT(REDIRECT_OUT),
  .NEW_PC_OUT(NEW_PC_OUT), .PRIV_OUT(PRIV_OUT), .IRQ_OUT(IRQ_OUT));

// ---- hiet_trap_if.sv ----
// bundle between the trap controller and the interrupt selector
`timescale 1ns/1ps
interface hiet_trap_if;
  import hiet_pkg::*;
  logic [63:0]       pending;
  logic [63:0]       enable;
  logic              global_en;
  logic              take;
  logic [CODE_W-1:0] code;
  modport ctl (output pending, output enable, output global_en, input take, input code);
  modport sel (input pending, input enable, input global_en, output take, output code);
endinterface : hiet_trap_if

// ---- testbench.sv ----
// self-checking bench for the hart interrupt entry/exit block
`timescale 1ns/1ps
module testbench
  import hiet_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, ecc_cor, slow, machine_trap_return_req;
  logic        redirect, irq, boundary, machine_trap_return, last_err, ecc_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, fab_irq, new_pc, pc;
  logic [5:0]  std_irq;
  logic [15:0] local_irq;
  logic [1:0]  priv;
  int          n_errors, checks_done;

  hiet_top i_dut (.CLK_IN(clk), .RST_IN(rst), .PADDR_IN(paddr), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .STD_IRQ_IN(std_irq), .LOCAL_IRQ_IN(local_irq), .FABRIC_IRQ_IN(fab_irq), .ECC_COR_IN(ecc_cor),
    .ECC_ERR_IN(ecc_err), .BOUNDARY_IN(boundary), .MACHINE_TRAP_RETURN_IN(machine_trap_return), .PC_IN(pc), .REDIRECT_OUT(redirect),
    .NEW_PC_OUT(new_pc), .PRIV_OUT(priv), .IRQ_OUT(irq));
  hiet_hart_model i_hart (.clk_in(clk), .rst_in(rst), .slow_in(slow), .machine_trap_return_req_in(machine_trap_return_req),
    .redirect_in(redirect), .new_pc_in(new_pc), .boundary_out(boundary), .machine_trap_return_out(machine_trap_return), .pc_out(pc));

  // ------------------------------------------
  // bus cycles and comparisons
  // ------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // releases the bus, so a finished transfer never repeats
  task automatic tick();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : tick

  task automatic wait_cyc(input int n);
    repeat (n) tick();
  endtask : wait_cyc

  // leaves the bus up so a following transfer can start at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    cmp(q, exp);
  endtask : rd

  task automatic wait_redir(input int k);
    int n;
    n = 0;
    while (i_hart.targets.size() < k && n < 100)
    begin
      tick();
      n++;
    end
    cmp(32'(i_hart.targets.size()), 32'(k));
  endtask : wait_redir

  // free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // cuts a hang short well past the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  initial
  begin
    {rst, psel, penable, pwrite, ecc_cor, slow, machine_trap_return_req, last_err} = 8'b1000_0000;
    {paddr, pwdata, fab_irq, std_irq, local_irq, ecc_err} = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick();
    rd(A_STATUS, 32'h0000_0000);
    rd(A_IE_LO, 32'h0000_0000);
    rd(A_FAB_EN, 32'hFFFF_FFFF);
    rd(A_PRIV, 32'h0000_0003);
    rd(8'h40, 32'h0000_0000);
    cmp({31'h0, last_err}, 32'h0000_0001);
    wr(A_IE_LO, 32'hFFFF_FFFF);
    wr(A_IE_HI, 32'hFFFF_FFFF);
    rd(A_IE_LO, 32'hFFFF_0AAA);
    rd(A_IE_HI, 32'hFFFF_FFFF);
    wr(A_STATUS, 32'h0000_1FF7);
    rd(A_STATUS, 32'h0000_1FF7);
    wr(A_STATUS, 32'h0000_0000);
    wr(A_TVEC, 32'h0000_0102);
    rd(A_TVEC, 32'h0000_0100);
    wr(A_TVEC, 32'h0000_0101);
    rd(A_TVEC, 32'h0000_0101);
    // a corrected then an uncorrectable event, both counted and flagged
    ecc_cor <= 1'b1;
    tick();
    {ecc_cor, ecc_err} <= 2'b01;
    tick();
    ecc_err <= 1'b0;
    wait_cyc(4);
    rd(A_ECC_ST, 32'h0000_0003);
    rd(A_ECC_CNT, 32'h0000_0002);
    rd(A_IP_LO, 32'h0000_0000);
    wr(A_ECC_IE, 32'h0000_0001);
    wait_cyc(4);
    rd(A_IP_LO, 32'h2000_0000);
    rd(A_EV_ST, 32'h0000_0004);
    // a set mask bit lets its event through to the interrupt line
    cmp({31'h0, irq}, 32'h0000_0000);
    wr(A_EV_MSK, 32'h0000_0004);
    wait_cyc(3);
    cmp({31'h0, irq}, 32'h0000_0001);
    wr(A_ECC_ST, 32'h0000_0001);
    wr(A_EV_ST, 32'h0000_0004);
    wr(A_EV_MSK, 32'h0000_0007);
    wait_cyc(4);
    cmp({31'h0, irq}, 32'h0000_0000);
    rd(A_ECC_ST, 32'h0000_0002);
    rd(A_IP_LO, 32'h0000_0000);
    wr(A_ECC_IE, 32'h0000_0000);
    // machine timer line pending while globally disabled
    std_irq <= 6'b00_1000;
    slow <= 1'b1;
    wait_cyc(10);
    cmp(32'(i_hart.targets.size()), 32'h0000_0000);
    rd(A_IP_LO, 32'h0000_0080);
    wr(A_STATUS, 32'h0000_0008);
    wait_redir(1);
    cmp(i_hart.targets[0], 32'h0000_011C);
    rd(A_STATUS, 32'h0000_1880);
    rd(A_EPC, 32'h0000_4000);
    rd(A_CAU_LO, 32'h0000_0007);
    rd(A_CAU_HI, 32'h8000_0000);
    rd(A_EV_ST, 32'h0000_0001);
    cmp({31'h0, irq}, 32'h0000_0001);
    // fabric line 0 becomes local 16 inside the handler
    std_irq <= 6'b00_0000;
    fab_irq <= 32'h0000_0001;
    wait_cyc(6);
    rd(A_IP_HI, 32'h0000_0001);
    wr(A_FAB_EN, 32'h0000_0000);
    wait_cyc(6);
    rd(A_IP_HI, 32'h0000_0000);
    wr(A_FAB_EN, 32'hFFFF_FFFF);
    wr(A_STATUS, 32'h0000_0080);
    wr(A_TVEC, 32'h0000_0200);
    machine_trap_return_req <= 1'b1;
    tick();
    machine_trap_return_req <= 1'b0;
    wait_redir(3);
    cmp(i_hart.targets[1], 32'h0000_4000);
    cmp(i_hart.targets[2], 32'h0000_0200);
    cmp({30'h0, priv}, 32'h0000_0003);
    rd(A_CAU_LO, 32'h0000_0020);
    // the return dropped to user mode, so the next entry records it
    rd(A_STATUS, 32'h0000_0080);
    rd(A_EV_ST, 32'h0000_0003);
    wr(A_EV_ST, 32'h0000_0007);
    wait_cyc(3);
    cmp({31'h0, irq}, 32'h0000_0000);
    rd(A_EV_ST, 32'h0000_0000);
    conclude();
  end
endmodule : testbench
